/* gae_pkg.sv */
// Purpose: Shared constants, register map and helpers for the gray absolute encoder block
// Assumes: Register indexes are word indexes; byte address is four times the index
// Notes:   Packed BCD values are four decimal digits in sixteen bits
package gae_pkg;

   // Sizes of the block
   localparam int NPORT = 2;            // Encoder ports
   localparam int NTGT = 48;            // Target value entries
   localparam int NRNG = 8;             // Range comparison entries
   localparam int NENT = 56;            // Entries walked by the compare scanner

   // Register indexes, byte address is index times four
   localparam logic [13:0] IDX_P1_POS = 14'h00e9;   // port1_position_value
   localparam logic [13:0] IDX_P2_LO = 14'h00ea;    // port2_position_low
   localparam logic [13:0] IDX_P2_HI = 14'h00eb;    // port2_position_high
   localparam logic [13:0] IDX_P1_OFF = 14'h19d3;   // port1_origin_offset
   localparam logic [13:0] IDX_P2_OFF = 14'h19d4;   // port2_origin_offset
   localparam logic [13:0] IDX_P1_CFG = 14'h19f3;   // port1_resolution_mode_cfg
   localparam logic [13:0] IDX_P2_CFG = 14'h19f4;   // port2_resolution_mode_cfg
   localparam logic [13:0] IDX_TGT = 14'h0100;      // Target table, 48 words
   localparam logic [13:0] IDX_RLIM = 14'h0140;     // Range limits, 8 words
   localparam logic [13:0] IDX_RCTL = 14'h0148;     // Range control, 8 words
   localparam logic [13:0] IDX_STATUS = 14'h0200;   // Sticky event status, read only
   localparam logic [13:0] IDX_CLEAR = 14'h0201;    // Status clear, write only
   localparam logic [13:0] IDX_IRQEN = 14'h0202;    // Interrupt enable
   localparam logic [13:0] IDX_VECTOR = 14'h0203;   // Last requested subroutine number
   localparam logic [13:0] IDX_FLAGS = 14'h0204;    // Direction and error flags

   // Setup word fields
   localparam int CFG_RES_LSB = 0;      // Resolution code, low byte
   localparam int CFG_MODE_LSB = 8;     // Count mode code, high byte
   localparam logic [7:0] RES_8 = 8'h00;
   localparam logic [7:0] RES_10 = 8'h01;
   localparam logic [7:0] RES_12 = 8'h02;
   localparam logic [7:0] MODE_BCD = 8'h00;
   localparam logic [7:0] MODE_DEG = 8'h01;

   // Table word fields
   localparam int TGT_SUB_LSB = 16;     // Subroutine number in target word
   localparam int TGT_PORT_BIT = 24;    // Port select, 0 port 1, 1 port 2
   localparam int TGT_EN_BIT = 31;      // Entry enable
   localparam int RLIM_HI_LSB = 16;     // Upper limit in range limit word
   localparam int RCTL_PORT_BIT = 8;    // Port select in range control word
   localparam int RCTL_EN_BIT = 31;     // Entry enable

   // Status bits
   localparam int NST = 3;
   localparam int ST_MATCH = 0;
   localparam int ST_RANGE = 1;
   localparam int ST_CFGERR = 2;

   // Reset values
   localparam logic [15:0] RST_CFG = 16'h0000;
   localparam logic [15:0] RST_OFF = 16'h0000;
   localparam logic [31:0] RST_WORD = 32'h0000_0000;
   localparam logic [13:0] DEG_FULL = 14'h0168;     // 360 degrees

   // Input mask for a resolution code
   function automatic logic [11:0] res_mask(input logic [7:0] res);
      case (res)
         RES_8: res_mask = 12'h0ff;
         RES_10: res_mask = 12'h3ff;
         default: res_mask = 12'hfff;
      endcase
   endfunction

   // Binary to packed BCD, shift and add three
   function automatic logic [15:0] bin2bcd(input logic [11:0] b);
      logic [27:0] s;
      int i;
      int j;
      s = {16'h0000, b};
      for (i = 0; i < 12; i++) begin
         for (j = 0; j < 4; j++) begin
            if (s[12 + 4 * j +: 4] > 4'h4) begin
               s[12 + 4 * j +: 4] = s[12 + 4 * j +: 4] + 4'h3;
            end
         end
         s = {s[26:0], 1'b0};
      end
      return s[27:12];
   endfunction

   // Packed BCD to binary
   function automatic logic [13:0] bcd2bin(input logic [15:0] d);
      return 14'(d[15:12]) * 14'h03e8 + 14'(d[11:8]) * 14'h0064 + 14'(d[7:4]) * 14'h000a + 14'(d[3:0]);
   endfunction

endpackage

/* gae_grayd.sv */
// Purpose: Gray code to binary decode for one encoder port
// Assumes: Input bits above the configured resolution are ignored
// Notes:   Purely combinational
`timescale 1ns/1ps
module gae_grayd (
   input wire logic [11:0] gray,
   input wire logic [7:0] res_code,
   output logic [11:0] bin
);

   logic [11:0] g;   // Gray word cut to resolution

   // Top bit copies gray, each lower bit folds in the bit above
   always_comb begin
      g = gray & gae_pkg::res_mask(res_code);
      bin[11] = g[11];
      for (int i = 10; i >= 0; i--) begin
         bin[i] = bin[i + 1] ^ g[i];
      end
   end

endmodule

/* gae_conv.sv */
// Purpose: Scale, origin shift, bound and BCD pack of one decoded position
// Assumes: bin already cut to the configured resolution
// Notes:   Offset at or beyond the span is treated as a setup error and ignored
`timescale 1ns/1ps
module gae_conv (
   input wire logic [11:0] bin,
   input wire logic [15:0] cfg,
   input wire logic [15:0] off_bcd,
   output logic [15:0] pv_bcd,
   output logic cfg_bad
);

   logic [7:0] res;      // Resolution code
   logic [7:0] mode;     // Count mode code
   logic [13:0] full;    // Positions per turn
   logic [21:0] prod;    // Scaled product
   logic [13:0] val;     // Value before origin shift
   logic [13:0] span;    // Span of the reported value
   logic [13:0] offb;    // Offset in binary
   logic [13:0] diff;    // Shifted value
   logic off_bad;        // Offset too large

   // Conversion path, all combinational
   always_comb begin
      res = cfg[gae_pkg::CFG_RES_LSB +: 8];
      mode = cfg[gae_pkg::CFG_MODE_LSB +: 8];
      full = 14'(gae_pkg::res_mask(res)) + 14'h0001;
      // Round to nearest by adding half a step; uses set resolution, not the real one
      prod = 22'(bin) * 22'(gae_pkg::DEG_FULL) + 22'(full >> 1);
      case (res)
         gae_pkg::RES_8: prod = prod >> 8;
         gae_pkg::RES_10: prod = prod >> 10;
         default: prod = prod >> 12;
      endcase
      val = (mode == gae_pkg::MODE_DEG) ? prod[13:0] : 14'(bin);
      span = (mode == gae_pkg::MODE_DEG) ? gae_pkg::DEG_FULL : full;
      offb = gae_pkg::bcd2bin(off_bcd);
      off_bad = (offb >= span);
      if (off_bad) begin
         offb = 14'h0000;
      end
      // Origin shift wraps inside the span; exact only when encoder matches setup
      if (val >= offb) begin
         diff = val - offb;
      end else begin
         diff = val + span - offb;
      end
      if (diff >= span) begin
         diff = span - 14'h0001;
      end
      pv_bcd = gae_pkg::bin2bcd(diff[11:0]);
      cfg_bad = (res > gae_pkg::RES_12) || (mode > gae_pkg::MODE_DEG) || off_bad;
   end

endmodule

/* gae_top.sv */
// Purpose: Two port gray absolute encoder counter with compare interrupts
// Assumes: Encoder inputs synchronous to sys_clk; Avalon-MM slave with one wait state
// Notes:   Compare tables are walked one entry per clock, far faster than the 4 kHz input rate
// Function
// - Low setup byte picks 8, 10, 12 bits
// - Accept gray word spanning 256, 1024, 4096
// - High setup byte picks BCD or degrees
// - Present value stored as four BCD digits
// - Port2 split over high/low words, port1 single
// - Value bounded by mode and resolution
// - 48 targets request subroutine on equality
// - 8 ranges request subroutine while inside
// - Any position can become the zero
// - One origin offset word per port
// - 8-bit degrees round N*360/256 to nearest
// - Degree scaling uses configured resolution
// - Origin shift valid only with matching resolution
// - BCD offset subtracted, 76..435 becomes 0..359
// - Invalid setup raises error indication
// - Per port increment and decrement indication
`timescale 1ns/1ps
module gae_top (
   input wire logic sys_clk,
   input wire logic rst_n,
   input wire logic [15:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_writedata,
   output logic [31:0] avs_readdata,
   output logic avs_waitrequest,
   input wire logic [11:0] port1_gray,
   input wire logic [11:0] port2_gray,
   output logic irq,
   output logic cfg_error,
   output logic port1_increment_flag,
   output logic port1_decrement_flag,
   output logic port2_increment_flag,
   output logic port2_decrement_flag
);

   // Whole state of the block
   typedef struct packed {
      logic waitreq;                                       // Avalon wait state
      logic [31:0] rdata;                                  // Read data register
      logic irq;                                           // Interrupt level
      logic [gae_pkg::NPORT-1:0][15:0] off;                // Origin offsets, BCD
      logic [gae_pkg::NPORT-1:0][15:0] cfg;                // Resolution and mode
      logic [gae_pkg::NTGT-1:0][15:0] tgt_val;             // Target values, BCD
      logic [gae_pkg::NTGT-1:0][7:0] tgt_sub;              // Target subroutine numbers
      logic [gae_pkg::NTGT-1:0] tgt_port;                  // Target port select
      logic [gae_pkg::NTGT-1:0] tgt_en;                    // Target enables
      logic [gae_pkg::NTGT-1:0] tgt_hit;                   // Last compare result
      logic [gae_pkg::NRNG-1:0][15:0] rng_lo;              // Lower limits, BCD
      logic [gae_pkg::NRNG-1:0][15:0] rng_hi;              // Upper limits, BCD
      logic [gae_pkg::NRNG-1:0][7:0] rng_sub;              // Range subroutine numbers
      logic [gae_pkg::NRNG-1:0] rng_port;                  // Range port select
      logic [gae_pkg::NRNG-1:0] rng_en;                    // Range enables
      logic [5:0] ptr;                                     // Scanner position
      logic [gae_pkg::NST-1:0] status;                     // Sticky events
      logic [gae_pkg::NST-1:0] irq_en;                     // Interrupt enables
      logic [7:0] vector;                                  // Last requested subroutine
      logic [gae_pkg::NPORT-1:0][15:0] pv;                 // Present values, BCD
      logic [gae_pkg::NPORT-1:0][11:0] prev;               // Last decoded binary
      logic [gae_pkg::NPORT-1:0] inc;                      // Incrementing flags
      logic [gae_pkg::NPORT-1:0] dec;                      // Decrementing flags
      logic err;                                           // Setup error level
   } gae_state_s;

   gae_state_s s;                                          // Registered state
   gae_state_s next_s;                                     // Next state

   logic [gae_pkg::NPORT-1:0][11:0] gray_in;               // Port inputs as array
   logic [gae_pkg::NPORT-1:0][11:0] bin;                   // Decoded binary per port
   logic [gae_pkg::NPORT-1:0][15:0] conv_pv;               // Converted BCD per port
   logic [gae_pkg::NPORT-1:0] conv_bad;                    // Setup error per port

   assign gray_in[0] = port1_gray;
   assign gray_in[1] = port2_gray;

   // One decode and convert path per port
   generate
      for (genvar p = 0; p < gae_pkg::NPORT; p++) begin : g_port
         gae_grayd u_grayd (
            .gray(gray_in[p]),
            .res_code(s.cfg[p][gae_pkg::CFG_RES_LSB +: 8]),
            .bin(bin[p])
         );
         gae_conv u_conv (
            .bin(bin[p]),
            .cfg(s.cfg[p]),
            .off_bcd(s.off[p]),
            .pv_bcd(conv_pv[p]),
            .cfg_bad(conv_bad[p])
         );
      end
   endgenerate

   // Next state: bus slave, port tracking, compare scanner, interrupts
   always_comb begin
      logic [13:0] idx;                                    // Word index of request
      logic [5:0] ti;                                      // Target table index
      logic [2:0] ri;                                      // Range table index
      logic [gae_pkg::NST-1:0] set;                        // Events this cycle
      logic [gae_pkg::NST-1:0] clr;                        // Clears this cycle
      logic [11:0] step;                                   // Modular input step
      logic [15:0] cmp_pv;                                 // Value under compare
      logic hit_now;                                       // Target equal now
      idx = avs_address[15:2];
      ti = 6'h00;
      ri = 3'h0;
      set = '0;
      clr = '0;
      step = 12'h000;
      cmp_pv = 16'h0000;
      hit_now = 1'b0;
      next_s = s;

      // Wait state: drop waitrequest for one cycle after a request is seen
      next_s.waitreq = 1'b1;
      if ((avs_read || avs_write) && s.waitreq) begin
         next_s.waitreq = 1'b0;
      end

      // Read data prepared during the wait cycle; unmapped reads give zero
      if (avs_read && s.waitreq) begin
         next_s.rdata = gae_pkg::RST_WORD;
         if (idx >= gae_pkg::IDX_TGT && idx < gae_pkg::IDX_TGT + 14'(gae_pkg::NTGT)) begin
            ti = 6'(idx - gae_pkg::IDX_TGT);
            next_s.rdata = {s.tgt_en[ti], 6'h00, s.tgt_port[ti], s.tgt_sub[ti], s.tgt_val[ti]};
         end else if (idx >= gae_pkg::IDX_RLIM && idx < gae_pkg::IDX_RCTL) begin
            ri = 3'(idx - gae_pkg::IDX_RLIM);
            next_s.rdata = {s.rng_hi[ri], s.rng_lo[ri]};
         end else if (idx >= gae_pkg::IDX_RCTL && idx < gae_pkg::IDX_RCTL + 14'(gae_pkg::NRNG)) begin
            ri = 3'(idx - gae_pkg::IDX_RCTL);
            next_s.rdata = {s.rng_en[ri], 22'h000000, s.rng_port[ri], s.rng_sub[ri]};
         end else begin
            case (idx)
               gae_pkg::IDX_P1_POS: next_s.rdata = {16'h0000, s.pv[0]};
               gae_pkg::IDX_P2_LO: next_s.rdata = {24'h000000, s.pv[1][7:0]};
               gae_pkg::IDX_P2_HI: next_s.rdata = {24'h000000, s.pv[1][15:8]};
               gae_pkg::IDX_P1_OFF: next_s.rdata = {16'h0000, s.off[0]};
               gae_pkg::IDX_P2_OFF: next_s.rdata = {16'h0000, s.off[1]};
               gae_pkg::IDX_P1_CFG: next_s.rdata = {16'h0000, s.cfg[0]};
               gae_pkg::IDX_P2_CFG: next_s.rdata = {16'h0000, s.cfg[1]};
               gae_pkg::IDX_STATUS: next_s.rdata = 32'(s.status);
               gae_pkg::IDX_IRQEN: next_s.rdata = 32'(s.irq_en);
               gae_pkg::IDX_VECTOR: next_s.rdata = {24'h000000, s.vector};
               gae_pkg::IDX_FLAGS: next_s.rdata = {27'h0000000, s.err, s.dec[1], s.inc[1], s.dec[0], s.inc[0]};
               default: next_s.rdata = gae_pkg::RST_WORD;
            endcase
         end
      end

      // Writes land on the edge where waitrequest is seen low; unmapped writes are dropped
      if (avs_write && !s.waitreq) begin
         if (idx >= gae_pkg::IDX_TGT && idx < gae_pkg::IDX_TGT + 14'(gae_pkg::NTGT)) begin
            ti = 6'(idx - gae_pkg::IDX_TGT);
            next_s.tgt_val[ti] = avs_writedata[15:0];
            next_s.tgt_sub[ti] = avs_writedata[gae_pkg::TGT_SUB_LSB +: 8];
            next_s.tgt_port[ti] = avs_writedata[gae_pkg::TGT_PORT_BIT];
            next_s.tgt_en[ti] = avs_writedata[gae_pkg::TGT_EN_BIT];
            next_s.tgt_hit[ti] = 1'b0;
         end else if (idx >= gae_pkg::IDX_RLIM && idx < gae_pkg::IDX_RCTL) begin
            ri = 3'(idx - gae_pkg::IDX_RLIM);
            next_s.rng_lo[ri] = avs_writedata[15:0];
            next_s.rng_hi[ri] = avs_writedata[gae_pkg::RLIM_HI_LSB +: 16];
         end else if (idx >= gae_pkg::IDX_RCTL && idx < gae_pkg::IDX_RCTL + 14'(gae_pkg::NRNG)) begin
            ri = 3'(idx - gae_pkg::IDX_RCTL);
            next_s.rng_sub[ri] = avs_writedata[7:0];
            next_s.rng_port[ri] = avs_writedata[gae_pkg::RCTL_PORT_BIT];
            next_s.rng_en[ri] = avs_writedata[gae_pkg::RCTL_EN_BIT];
         end else begin
            case (idx)
               gae_pkg::IDX_P1_OFF: next_s.off[0] = avs_writedata[15:0];
               gae_pkg::IDX_P2_OFF: next_s.off[1] = avs_writedata[15:0];
               gae_pkg::IDX_P1_CFG: next_s.cfg[0] = avs_writedata[15:0];
               gae_pkg::IDX_P2_CFG: next_s.cfg[1] = avs_writedata[15:0];
               gae_pkg::IDX_CLEAR: clr = avs_writedata[gae_pkg::NST-1:0];
               gae_pkg::IDX_IRQEN: next_s.irq_en = avs_writedata[gae_pkg::NST-1:0];
               default: ;
            endcase
         end
      end

      // Port tracking: store value and direction of each change
      for (int p = 0; p < gae_pkg::NPORT; p++) begin
         next_s.pv[p] = conv_pv[p];
         if (bin[p] != s.prev[p]) begin
            // Step taken modulo one turn so a wrap through zero keeps its direction
            step = (bin[p] - s.prev[p]) & gae_pkg::res_mask(s.cfg[p][gae_pkg::CFG_RES_LSB +: 8]);
            next_s.inc[p] = ((step & (gae_pkg::res_mask(s.cfg[p][gae_pkg::CFG_RES_LSB +: 8]) >> 1)) == step);
            next_s.dec[p] = !next_s.inc[p];
            next_s.prev[p] = bin[p];
         end
      end

      // Setup error is a level and also a sticky event
      next_s.err = |conv_bad;
      set[gae_pkg::ST_CFGERR] = next_s.err;

      // Scanner visits one table entry per clock
      if (s.ptr < 6'(gae_pkg::NTGT)) begin
         ti = s.ptr;
         cmp_pv = s.tgt_port[ti] ? s.pv[1] : s.pv[0];
         hit_now = s.tgt_en[ti] && (cmp_pv == s.tgt_val[ti]);
         // Fires once on arrival at the target, not every pass while parked on it
         if (hit_now && !s.tgt_hit[ti]) begin
            set[gae_pkg::ST_MATCH] = 1'b1;
            next_s.vector = s.tgt_sub[ti];
         end
         if (!(avs_write && !s.waitreq && idx == gae_pkg::IDX_TGT + 14'(ti))) begin
            next_s.tgt_hit[ti] = hit_now;
         end
      end else begin
         ri = 3'(s.ptr - 6'(gae_pkg::NTGT));
         cmp_pv = s.rng_port[ri] ? s.pv[1] : s.pv[0];
         // Range requests repeat on every pass while the value stays inside
         if (s.rng_en[ri] && cmp_pv >= s.rng_lo[ri] && cmp_pv <= s.rng_hi[ri]) begin
            set[gae_pkg::ST_RANGE] = 1'b1;
            next_s.vector = s.rng_sub[ri];
         end
      end
      next_s.ptr = (s.ptr == 6'(gae_pkg::NENT - 1)) ? 6'h00 : s.ptr + 6'h01;

      // Sticky status: an event in the clear cycle survives
      next_s.status = (s.status & ~clr) | set;
      next_s.irq = |(next_s.status & next_s.irq_en);
   end

   // State register
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         s <= '0;
         s.waitreq <= 1'b1;
         s.off <= {gae_pkg::RST_OFF, gae_pkg::RST_OFF};
         s.cfg <= {gae_pkg::RST_CFG, gae_pkg::RST_CFG};
      end else begin
         s <= next_s;
      end
   end

   // Outputs straight from the state register
   assign avs_readdata = s.rdata;
   assign avs_waitrequest = s.waitreq;
   assign irq = s.irq;
   assign cfg_error = s.err;
   assign port1_increment_flag = s.inc[0];
   assign port1_decrement_flag = s.dec[0];
   assign port2_increment_flag = s.inc[1];
   assign port2_decrement_flag = s.dec[1];

endmodule

/* gae_enc_model.sv */
// Purpose: Absolute encoder model that turns a shaft position into a gray word
// Assumes: Position is driven by the bench at the clock edge
// Notes:   Parallel outputs change at once, like a real encoder
`timescale 1ns/1ps
module gae_enc_model (
   input wire logic [11:0] pos,
   output logic [11:0] gray
);
   // Adjacent positions differ in one bit only
   assign gray = pos ^ (pos >> 1);
endmodule

/* gae_checker.sv */
// Purpose: Pin level assertions for the gray absolute encoder block
// Assumes: One clock domain, reset asynchronous and active low
// Notes:   Status and tables are internal, so checks tie bus and flag pins
`timescale 1ns/1ps
module gae_checker (
   input wire logic sys_clk,
   input wire logic rst_n,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_readdata,
   input wire logic avs_waitrequest,
   input wire logic [11:0] port1_gray,
   input wire logic cfg_error,
   input wire logic port1_increment_flag,
   input wire logic port1_decrement_flag
);
   default clocking dc @(posedge sys_clk); endclocking
   default disable iff (!rst_n);
   // Bus answers after exactly one wait state, for one cycle only
   a_wait_one: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
      else $error("no answer after one wait state");
   a_wait_pulse: assert property (!avs_waitrequest |=> avs_waitrequest)
      else $error("answer longer than one cycle");
   a_wait_cause: assert property (!(avs_read || avs_write) |=> avs_waitrequest)
      else $error("answer without request");
   // Read data moves only in the answer cycle of a read
   a_rdata_answer: assert property ($changed(avs_readdata) |-> !avs_waitrequest)
      else $error("read data moved outside answer");
   a_rdata_read: assert property ($changed(avs_readdata) |-> $past(avs_read))
      else $error("read data moved without read");
   // Direction flags: never both, and only after a new input or setup write
   a_dir_excl: assert property (!(port1_increment_flag && port1_decrement_flag))
      else $error("both direction flags set");
   a_dir_hold: assert property ($stable(port1_gray) && $past(rst_n) && !avs_write && !$past(avs_write) |=>
      $stable({port1_increment_flag, port1_decrement_flag})) else $error("direction moved without input");
   a_cfgerr_cause: assert property ($changed(cfg_error) |-> $past(avs_write) || $past(avs_write, 2))
      else $error("setup error moved without write");
   cover property (port1_decrement_flag);
   cover property (cfg_error);
   cover property (avs_read && !avs_waitrequest);
endmodule
bind gae_top gae_checker u_chk (.sys_clk(sys_clk), .rst_n(rst_n), .avs_read(avs_read), .avs_write(avs_write),
   .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .port1_gray(port1_gray), .cfg_error(cfg_error),
   .port1_increment_flag(port1_increment_flag), .port1_decrement_flag(port1_decrement_flag));

/* testbench.sv */
// Purpose: Self-checking bench for the gray absolute encoder block
// Assumes: Encoder models turn shaft positions into gray words
// Notes:   Compare waits use the 56 cycle scanner bound plus margin
`timescale 1ns/1ps
module testbench;
   logic sys_clk = 0, rst_n = 0, avs_read = 0, avs_write = 0;
   logic [15:0] avs_address = '0;
   logic [31:0] avs_writedata = '0, avs_readdata, rdat; // rdat is the last answer
   logic [11:0] pos1 = '0, pos2 = '0, port1_gray, port2_gray; // Shaft positions and wires
   logic avs_waitrequest, irq, cfg_error;
   logic [3:0] dirf; // p1 inc, p1 dec, p2 inc, p2 dec
   logic [15:0] e; // Expected packed digits
   int n_fail = 0, tests_run = 0, b;
   always #4 sys_clk = ~sys_clk;
   gae_enc_model enc1 (.pos(pos1), .gray(port1_gray));
   gae_enc_model enc2 (.pos(pos2), .gray(port2_gray));
   gae_top DUT (.sys_clk(sys_clk), .rst_n(rst_n), .avs_address(avs_address), .avs_read(avs_read),
      .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
      .avs_waitrequest(avs_waitrequest), .port1_gray(port1_gray), .port2_gray(port2_gray), .irq(irq),
      .cfg_error(cfg_error), .port1_increment_flag(dirf[0]), .port1_decrement_flag(dirf[1]),
      .port2_increment_flag(dirf[2]), .port2_decrement_flag(dirf[3]));
   // Packed digits worked out by division, independent of the design
   function automatic logic [15:0] bcd(input int v);
      return {4'(v / 1000 % 10), 4'(v / 100 % 10), 4'(v / 10 % 10), 4'(v % 10)};
   endfunction
   // Degrees rounded to nearest over b bits, or the plain count
   // A value that rounds up to a full turn is held at 359, the top of the span
   function automatic int scl(input int v, input int deg);
      int d;
      d = (v * 360 + (1 << (b - 1))) >> b;
      return deg ? ((d > 359) ? 359 : d) : v;
   endfunction
   task automatic chk(input string n, input logic [31:0] x, input logic [31:0] g);
      tests_run++;
      if (g !== x) begin
         n_fail++;
         $display("unexpected %s expected %h seen %h", n, x, g);
      end
   endtask
   // One transfer held until waitrequest is seen low; a read compares with d
   task automatic xfer(input string n, input logic w, input logic [13:0] i, input logic [31:0] d);
      @(posedge sys_clk);
      avs_address <= {i, 2'b00};
      avs_writedata <= d;
      avs_write <= w;
      avs_read <= !w;
      do @(negedge sys_clk);
      while (avs_waitrequest !== 1'b0);
      rdat = avs_readdata;
      @(posedge sys_clk);
      avs_write <= 0;
      avs_read <= 0;
      if (!w) chk(n, d, rdat);
   endtask
   task automatic summarize;
      $display("checks %0d mismatches %0d", tests_run, n_fail);
      if (n_fail == 0 && tests_run > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask
   // Main sequence
   initial begin
      repeat (8) @(posedge sys_clk);
      rst_n <= 1;
      xfer("cfg1", 0, gae_pkg::IDX_P1_CFG, '0);
      xfer("spare", 0, 14'h0300, '0);
      // Every resolution code in both count modes, full scale on port 1 and one below full scale on port 2
      for (int r = 0; r < 6; r++) begin
         b = 8 + 2 * (r % 3);
         xfer("cfg1", 1, gae_pkg::IDX_P1_CFG, {16'h0, 8'(r / 3), 8'(r % 3)});
         xfer("cfg2", 1, gae_pkg::IDX_P2_CFG, {16'h0, 8'(r / 3), 8'(r % 3)});
         pos1 <= 12'((1 << b) - 1);
         pos2 <= 12'((1 << b) - 2);
         repeat (3) @(posedge sys_clk);
         xfer("pos1", 0, gae_pkg::IDX_P1_POS, {16'h0, bcd(scl((1 << b) - 1, r / 3))});
         e = bcd(scl((1 << b) - 2, r / 3));
         xfer("pos2hi", 0, gae_pkg::IDX_P2_HI, {24'h0, e[15:8]});
         xfer("pos2lo", 0, gae_pkg::IDX_P2_LO, {24'h0, e[7:0]});
      end
      pos1 <= 12'h001;
      pos2 <= 12'hffd;
      repeat (3) @(posedge sys_clk);
      chk("dir", 32'h9, 32'(dirf));
      xfer("cfg1", 1, gae_pkg::IDX_P1_CFG, 32'h0000_0002);
      xfer("off1", 1, gae_pkg::IDX_P1_OFF, 32'h0000_0076);
      pos1 <= 12'd75;
      repeat (3) @(posedge sys_clk);
      xfer("pos1", 0, gae_pkg::IDX_P1_POS, 32'h4095);
      xfer("ro", 1, gae_pkg::IDX_P1_POS, 32'h1234);
      xfer("irqen", 1, gae_pkg::IDX_IRQEN, 32'h1);
      xfer("tgt", 1, gae_pkg::IDX_TGT + 14'd5, 32'h802a_0000);
      pos1 <= 12'd76;
      repeat (60) @(posedge sys_clk);
      chk("irq", 32'h1, {31'h0, irq});
      xfer("pos1", 0, gae_pkg::IDX_P1_POS, '0);
      xfer("vector", 0, gae_pkg::IDX_VECTOR, 32'h2a);
      xfer("clear", 1, gae_pkg::IDX_CLEAR, 32'h1);
      xfer("rlim", 1, gae_pkg::IDX_RLIM, 32'h0010_0000);
      xfer("rctl", 1, gae_pkg::IDX_RCTL, 32'h8000_0033);
      repeat (60) @(posedge sys_clk);
      chk("irq", 32'h0, {31'h0, irq});
      xfer("status", 0, gae_pkg::IDX_STATUS, 32'h2);
      xfer("cfg1", 1, gae_pkg::IDX_P1_CFG, 32'h0000_0003);
      repeat (3) @(posedge sys_clk);
      chk("cfgerr", 32'h1, {31'h0, cfg_error});
      summarize();
   end
   // Watchdog far beyond the expected run of about three hundred cycles
   initial begin
      repeat (5000) @(posedge sys_clk);
      n_fail++;
      summarize();
   end
endmodule
